// *** logic/twd_top.sv ***
// Timer and watchdog control registers, prescaler, periodic timer and watchdog counter.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module twd_top import twd_pkg::*; #(
	parameter int XFER_CYCLES = XFER_SLOW_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic SLOW_CLOCK,
	input wire logic DEBUG_FREEZE,
	input wire twd_req_s REG_REQ,
	output logic [DATA_W-1:0] RDATA,
	output logic TIMER_IRQ,
	output logic TIMER_UNDERFLOW_PULSE,
	output logic PRESCALED_TICK,
	output logic WD_ERROR_RESET
);
	if (XFER_CYCLES < 1 || XFER_CYCLES > 7) begin : g_bad_xfer
		$error("XFER_CYCLES must lie in 1..7");
	end

	logic [1:0] slow_sync_ff;
	logic [1:0] frz_sync_ff;
	logic slow_prev_ff;
	logic slow_edge;
	logic freeze;
	logic [5:0] cfg_ff;
	logic [2:0] div_ff;
	logic [15:0] reload_ff;
	logic restart_ff;
	logic terminal_ff;
	logic irq_en_ff;
	logic halt_en_ff;
	logic [7:0] count_load_ff;
	logic [4:0] pre_cnt_ff;
	logic [4:0] pre_limit;
	logic tick;
	logic [15:0] timer_ff;
	logic timer_run;
	logic underflow;
	logic [7:0] wd_cnt_ff;
	logic wd_started_ff;
	logic wd_serviced_ff;
	logic wd_clk_en;
	logic wd_error_ff;
	logic [2:0] pend_cnt_ff;
	logic wr_config, wr_presc, wr_reload, wr_cs, wr_count, wr_match;
	logic rd_cs;
	logic service_req;
	logic match_bad;
	logic [7:0] wbyte;

	// Both pins come from outside the core clock domain.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			slow_sync_ff <= 2'h0;
			frz_sync_ff <= 2'h0;
			slow_prev_ff <= 1'b0;
		end else begin
			slow_sync_ff <= {slow_sync_ff[0], SLOW_CLOCK};
			frz_sync_ff <= {frz_sync_ff[0], DEBUG_FREEZE};
			slow_prev_ff <= slow_sync_ff[1];
		end
	end
	assign slow_edge = slow_sync_ff[1] & ~slow_prev_ff;
	assign freeze = frz_sync_ff[1];

	assign wbyte = REG_REQ.wdata[7:0];
	// A locked register takes no write at all.
	assign wr_config = REG_REQ.wr && REG_REQ.addr == OFS_CONFIG && !cfg_ff[CFG_LOCK_CONFIG];
	assign wr_presc = REG_REQ.wr && REG_REQ.addr == OFS_PRESCALER && !cfg_ff[CFG_LOCK_PRESCALER];
	assign wr_reload = REG_REQ.wr && REG_REQ.addr == OFS_RELOAD && !cfg_ff[CFG_LOCK_TIMER];
	assign wr_cs = REG_REQ.wr && REG_REQ.addr == OFS_CTRL_STATUS && !cfg_ff[CFG_LOCK_TIMER];
	assign wr_count = REG_REQ.wr && REG_REQ.addr == OFS_COUNT_LOAD && !cfg_ff[CFG_LOCK_COUNT];
	assign wr_match = REG_REQ.wr && REG_REQ.addr == OFS_MATCH && cfg_ff[CFG_MATCH_ENABLE];
	assign rd_cs = REG_REQ.rd && REG_REQ.addr == OFS_CTRL_STATUS && !cfg_ff[CFG_LOCK_TIMER];

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg_ff <= CFG_RESET;
		end else if (wr_config) begin
			// Lock bits can only be set; a clear attempt leaves them as they are.
			cfg_ff <= wbyte[5:0] | (cfg_ff & CFG_LOCK_MASK);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_ff <= DIV_RESET;
		end else if (wr_presc) begin
			div_ff <= wbyte[2:0];
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			reload_ff <= RELOAD_RESET;
		end else if (wr_reload) begin
			reload_ff <= REG_REQ.wdata;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_en_ff <= 1'b0;
			halt_en_ff <= 1'b0;
		end else if (wr_cs) begin
			irq_en_ff <= wbyte[CS_IRQ_ENABLE];
			halt_en_ff <= wbyte[CS_HALT_ENABLE];
		end
	end

	// Restart request is taken on the next tick; a new write of 1 wins over that clear.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			restart_ff <= 1'b0;
		end else if (wr_cs && wbyte[CS_RESTART]) begin
			restart_ff <= 1'b1;
		end else if (tick && timer_run) begin
			restart_ff <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			terminal_ff <= 1'b0;
		end else if (underflow) begin
			terminal_ff <= 1'b1;
		end else if (rd_cs && !freeze) begin
			terminal_ff <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			count_load_ff <= COUNT_LOAD_RESET;
		end else if (wr_count) begin
			count_load_ff <= wbyte;
		end
	end

	// Reserved codes fall back to the slowest divisor.
	always_comb begin
		pre_limit = 5'((6'h01 << DIV_MAX_CODE) - 6'h01);
		if (div_ff <= DIV_MAX_CODE) begin
			pre_limit = 5'((6'h01 << div_ff) - 6'h01);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pre_cnt_ff <= 5'h00;
		end else if (slow_edge) begin
			pre_cnt_ff <= (pre_cnt_ff >= pre_limit) ? 5'h00 : pre_cnt_ff + 5'h01;
		end
	end
	assign tick = slow_edge && pre_cnt_ff >= pre_limit;

	assign timer_run = !(freeze && halt_en_ff);
	assign underflow = tick && timer_run && !restart_ff && timer_ff == 16'h0000;

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			timer_ff <= RELOAD_RESET;
		end else if (tick && timer_run) begin
			if (restart_ff || timer_ff == 16'h0000) begin
				timer_ff <= reload_ff;
			end else begin
				timer_ff <= timer_ff - 16'h0001;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			TIMER_UNDERFLOW_PULSE <= 1'b0;
			TIMER_IRQ <= 1'b0;
			PRESCALED_TICK <= 1'b0;
		end else begin
			TIMER_UNDERFLOW_PULSE <= underflow;
			TIMER_IRQ <= underflow && irq_en_ff;
			PRESCALED_TICK <= tick;
		end
	end

	// The watchdog clock is an enable pulse, so the freeze simply withholds it.
	assign wd_clk_en = (cfg_ff[CFG_WD_FROM_TICK] ? tick : underflow) && !freeze;
	assign match_bad = wr_match && wbyte != MATCH_KEY;
	assign service_req = (wr_count && !cfg_ff[CFG_MATCH_ENABLE]) || (wr_match && wbyte == MATCH_KEY);

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wd_started_ff <= 1'b0;
		end else if (wr_count || wr_match) begin
			wd_started_ff <= 1'b1;
		end
	end

	// Counting-register writes always reload; a match write with the key reloads the stored count.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wd_cnt_ff <= COUNT_LOAD_RESET;
		end else if (wr_count) begin
			wd_cnt_ff <= wbyte;
		end else if (service_req) begin
			wd_cnt_ff <= count_load_ff;
		end else if (wd_started_ff && wd_clk_en && wd_cnt_ff != 8'h00) begin
			wd_cnt_ff <= wd_cnt_ff - 8'h01;
		end
	end

	// Marks a service inside the current watchdog clock period; a service in the clock cycle wins.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wd_serviced_ff <= 1'b0;
		end else if (service_req && wd_started_ff) begin
			wd_serviced_ff <= 1'b1;
		end else if (wd_clk_en) begin
			wd_serviced_ff <= 1'b0;
		end
	end

	// The error is held until the device reset it requests comes back to this block.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wd_error_ff <= 1'b0;
		end else if (match_bad) begin
			wd_error_ff <= 1'b1;
		end else if (service_req && wd_serviced_ff) begin
			wd_error_ff <= 1'b1;
		end else if (wd_started_ff && wd_clk_en && wd_cnt_ff == 8'h00 && !service_req) begin
			wd_error_ff <= 1'b1;
		end
	end
	assign WD_ERROR_RESET = wd_error_ff;

	// The transfer into the slow-clocked watchdog is taken as complete after a few slow edges.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pend_cnt_ff <= 3'h0;
		end else if (wr_count || wr_match) begin
			pend_cnt_ff <= 3'(XFER_CYCLES);
		end else if (slow_edge && pend_cnt_ff != 3'h0) begin
			pend_cnt_ff <= pend_cnt_ff - 3'h1;
		end
	end

	// Locked registers read as zero; software must not rely on that value.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RDATA <= 16'h0000;
		end else if (REG_REQ.rd) begin
			RDATA <= 16'h0000;
			unique case (REG_REQ.addr)
				OFS_CONFIG: if (!cfg_ff[CFG_LOCK_CONFIG]) RDATA <= {10'h000, cfg_ff};
				OFS_PRESCALER: if (!cfg_ff[CFG_LOCK_PRESCALER]) RDATA <= {13'h0000, div_ff};
				OFS_RELOAD: if (!cfg_ff[CFG_LOCK_TIMER]) RDATA <= reload_ff;
				OFS_CTRL_STATUS: if (!cfg_ff[CFG_LOCK_TIMER]) begin
					RDATA <= {11'h000, halt_en_ff, pend_cnt_ff != 3'h0, irq_en_ff, terminal_ff, restart_ff};
				end
				default: RDATA <= 16'h0000;
			endcase
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);

	a_cfg_lock_sticky: assert property (
		$past(cfg_ff[CFG_LOCK_CONFIG]) |-> cfg_ff[CFG_LOCK_CONFIG] && cfg_ff == $past(cfg_ff))
		else $error("locked config register changed");
	a_lock_bits_hold: assert property (
		(cfg_ff & CFG_LOCK_MASK) != 6'h00 |=> ((cfg_ff & CFG_LOCK_MASK) & $past(cfg_ff & CFG_LOCK_MASK)) == $past(cfg_ff & CFG_LOCK_MASK))
		else $error("a lock bit was cleared");
	a_reload_locked: assert property (
		cfg_ff[CFG_LOCK_TIMER] |=> $stable(reload_ff) && $stable(irq_en_ff) && $stable(halt_en_ff))
		else $error("timer registers changed while locked");
	a_timer_reload: assert property (
		tick && timer_run && timer_ff == 16'h0000 |=> timer_ff == $past(reload_ff))
		else $error("timer did not reload on underflow");
	a_timer_decrement: assert property (
		tick && timer_run && !restart_ff && timer_ff != 16'h0000 |=> timer_ff == $past(timer_ff) - 16'h0001)
		else $error("timer did not count down on tick");
	a_restart_clears: assert property (
		restart_ff && tick && timer_run && !wr_cs |=> !restart_ff && timer_ff == $past(reload_ff))
		else $error("restart did not reload and clear");
	a_irq_gated: assert property (
		underflow |=> TIMER_IRQ == $past(irq_en_ff) && TIMER_UNDERFLOW_PULSE && terminal_ff)
		else $error("interrupt or terminal count wrong after underflow");
	a_tc_freeze_keep: assert property (
		terminal_ff && freeze && rd_cs |=> terminal_ff)
		else $error("terminal count cleared during freeze");
	a_wd_frozen: assert property (
		freeze && !wr_count && !wr_match |=> $stable(wd_cnt_ff))
		else $error("watchdog moved during freeze");
	a_wd_idle_reset: assert property (
		!wd_started_ff && !wr_count |=> wd_cnt_ff == $past(wd_cnt_ff))
		else $error("watchdog counted before start");
	a_match_bad_err: assert property (
		match_bad |=> wd_error_ff ##1 wd_error_ff)
		else $error("wrong match value gave no error");
	a_late_service: assert property (
		wd_started_ff && wd_clk_en && wd_cnt_ff == 8'h00 && !service_req |=> WD_ERROR_RESET)
		else $error("watchdog expiry gave no error");
	a_pending_flag: assert property (
		wr_count |=> pend_cnt_ff != 3'h0 ##1 pend_cnt_ff != 3'h0)
		else $error("transfer pending flag not raised");
	// Reset values are checked on the first edge after release, before any write can land.
	a_reset_regs: assert property (
		$rose(RESET_N) |-> cfg_ff == CFG_RESET && div_ff == DIV_RESET && !irq_en_ff && !halt_en_ff && !terminal_ff)
		else $error("control registers not cleared by reset");
	a_reload_reset: assert property (
		$rose(RESET_N) |-> reload_ff == RELOAD_RESET && timer_ff == RELOAD_RESET)
		else $error("reload value not all ones after reset");
	a_count_reset: assert property (
		$rose(RESET_N) |-> count_load_ff == COUNT_LOAD_RESET && wd_cnt_ff == COUNT_LOAD_RESET && !wd_started_ff)
		else $error("count register or watchdog wrong after reset");
	a_presc_locked: assert property (
		cfg_ff[CFG_LOCK_PRESCALER] |=> $stable(div_ff))
		else $error("prescaler changed while locked");
	a_count_locked: assert property (
		cfg_ff[CFG_LOCK_COUNT] |=> $stable(count_load_ff) && $stable(wd_started_ff))
		else $error("count register changed while locked");
	a_locked_read: assert property (
		REG_REQ.rd && REG_REQ.addr == OFS_PRESCALER && cfg_ff[CFG_LOCK_PRESCALER] |=> RDATA == 16'h0000)
		else $error("locked prescaler read returned data");
	a_reserved_cfg: assert property (
		REG_REQ.rd && REG_REQ.addr == OFS_CONFIG |=> RDATA[7:6] == 2'h0)
		else $error("reserved config bits read as one");
	a_wd_clk_select: assert property (
		wd_clk_en |-> !freeze && (cfg_ff[CFG_WD_FROM_TICK] ? tick : underflow))
		else $error("watchdog clocked from wrong source");
	a_match_ignored: assert property (
		REG_REQ.wr && REG_REQ.addr == OFS_MATCH && !cfg_ff[CFG_MATCH_ENABLE] && !wd_started_ff |=> !wd_started_ff)
		else $error("match write acted while match service off");
	a_count_reload: assert property (
		wr_count |=> wd_cnt_ff == $past(wbyte))
		else $error("count write did not reload watchdog");
	a_match_reload: assert property (
		wr_match && wbyte == MATCH_KEY |=> wd_cnt_ff == $past(count_load_ff))
		else $error("match service did not reload stored count");
	a_tick_div_one: assert property (
		slow_edge && div_ff == 3'h0 |-> tick)
		else $error("divide by one missed a slow edge");
	a_tick_pin: assert property (
		tick |=> PRESCALED_TICK)
		else $error("prescaled tick not shown on output");
	a_timer_steady: assert property (
		!(tick && timer_run) |=> $stable(timer_ff))
		else $error("timer moved without a tick");
	a_irq_quiet: assert property (
		!underflow |=> !TIMER_IRQ && !TIMER_UNDERFLOW_PULSE)
		else $error("timer pulse without underflow");
	a_tc_read_clear: assert property (
		rd_cs && !freeze && !underflow |=> !terminal_ff)
		else $error("terminal count not cleared by read");
	a_tc_write_ignored: assert property (
		wr_cs && !REG_REQ.rd && !underflow |=> terminal_ff == $past(terminal_ff))
		else $error("write changed terminal count");
	a_restart_set: assert property (
		wr_cs && wbyte[CS_RESTART] |=> restart_ff)
		else $error("restart write not taken");
	a_pend_clear: assert property (
		pend_cnt_ff == 3'h0 && !wr_count && !wr_match |=> pend_cnt_ff == 3'h0)
		else $error("pending flag rose without a write");
	a_timer_halted: assert property (
		freeze && halt_en_ff |=> $stable(timer_ff))
		else $error("timer ran during halting freeze");
	a_timer_free: assert property (
		tick && freeze && !halt_en_ff && !restart_ff && timer_ff != 16'h0000 |=> timer_ff == $past(timer_ff) - 16'h0001)
		else $error("timer stopped by freeze without halt enable");
	a_too_often: assert property (
		service_req && wd_serviced_ff |=> WD_ERROR_RESET)
		else $error("early service gave no error");
	a_double_match: assert property (
		wr_match && $past(wr_match) && $past(wd_started_ff) |=> WD_ERROR_RESET)
		else $error("back to back match writes gave no error");
	a_wd_count_down: assert property (
		wd_started_ff && wd_clk_en && !wr_count && !service_req && wd_cnt_ff != 8'h00 |=> wd_cnt_ff == $past(wd_cnt_ff) - 8'h01)
		else $error("watchdog did not count down");
	a_error_sticky: assert property (
		WD_ERROR_RESET |=> WD_ERROR_RESET)
		else $error("watchdog error dropped before reset");
endmodule

// *** logic/twd_pkg.sv ***
// Constants, field positions and bus carrier of the timer and watchdog control block.
package twd_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_PRESCALER = 8'h22;
	localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 8'h26;
	localparam logic [ADDR_W-1:0] OFS_COUNT_LOAD = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_MATCH = 8'h2a;
	localparam int CFG_LOCK_CONFIG = 0;
	localparam int CFG_LOCK_PRESCALER = 1;
	localparam int CFG_LOCK_TIMER = 2;
	localparam int CFG_LOCK_COUNT = 3;
	localparam int CFG_WD_FROM_TICK = 4;
	localparam int CFG_MATCH_ENABLE = 5;
	localparam logic [5:0] CFG_LOCK_MASK = 6'h0f;
	localparam int CS_RESTART = 0;
	localparam int CS_TERMINAL = 1;
	localparam int CS_IRQ_ENABLE = 2;
	localparam int CS_PENDING = 3;
	localparam int CS_HALT_ENABLE = 4;
	localparam logic [5:0] CFG_RESET = 6'h00;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam logic [2:0] DIV_MAX_CODE = 3'h5;
	localparam logic [15:0] RELOAD_RESET = 16'hffff;
	localparam logic [7:0] COUNT_LOAD_RESET = 8'h0f;
	localparam logic [7:0] MATCH_KEY = 8'h5c;
	localparam int XFER_SLOW_CYCLES = 5;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} twd_req_s;
endpackage

// *** tb/twd_tb.sv ***
// Self-checking testbench for the timer and watchdog control block.
`timescale 1ns/1ps
module testbench import twd_pkg::*;;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic slow_clock = 1'b0;
	logic debug_freeze = 1'b0;
	twd_req_s req = '0;
	logic [DATA_W-1:0] rdata;
	logic timer_irq, underflow, tick, wd_err;
	logic [1:0] sc_div = 2'h0;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int uf_cnt = 0;
	int irq_cnt = 0;
	int g, u0, i0;

	twd_top #(.XFER_CYCLES(2)) u_dut (
		.CORE_CLK(core_clk),
		.RESET_N(reset_n),
		.SLOW_CLOCK(slow_clock),
		.DEBUG_FREEZE(debug_freeze),
		.REG_REQ(req),
		.RDATA(rdata),
		.TIMER_IRQ(timer_irq),
		.TIMER_UNDERFLOW_PULSE(underflow),
		.PRESCALED_TICK(tick),
		.WD_ERROR_RESET(wd_err)
	);

	always #5 core_clk = ~core_clk;

	// The slow clock runs free at one eighth of the core clock, inside the synchroniser's limit.
	always @(posedge core_clk) begin
		sc_div <= sc_div + 2'h1;
		if (&sc_div) begin
			slow_clock <= ~slow_clock;
		end
	end

	always @(posedge core_clk) begin
		uf_cnt <= uf_cnt + int'(underflow);
		irq_cnt <= irq_cnt + int'(timer_irq);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic idle(input int n);
		req <= '0;
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		req <= '0;
		@(posedge core_clk);
		chk($sformatf("read %h", a), exp, rdata);
	endtask

	// Cycles between two pulses of the underflow (s=1) or the prescaled tick (s=0).
	task automatic gap(input bit s, output int n);
		int w;
		w = 0;
		n = 0;
		req <= '0;
		do begin
			@(negedge core_clk);
			w++;
		end while (!(s ? underflow : tick) && w < 3000);
		do begin
			@(negedge core_clk);
			n++;
		end while (!(s ? underflow : tick) && n < 3000);
		@(posedge core_clk);
	endtask

	task automatic reset_dut();
		reset_n <= 1'b0;
		req <= '0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
	endtask

	initial begin
		reset_dut();
		rd_chk(OFS_CONFIG, 16'h0000);
		rd_chk(OFS_PRESCALER, 16'h0000);
		rd_chk(OFS_RELOAD, 16'hffff);
		rd_chk(OFS_CTRL_STATUS, 16'h0000);
		rd_chk(8'h30, 16'h0000);
		wr(OFS_CONFIG, 16'h00f0);
		rd_chk(OFS_CONFIG, 16'h0030);
		wr(OFS_CONFIG, 16'h0000);
		wr(OFS_PRESCALER, 16'h00ff);
		rd_chk(OFS_PRESCALER, 16'h0007);
		for (int c = 0; c < 7; c++) begin
			wr(OFS_PRESCALER, 16'(c));
			gap(0, g);
			gap(0, g);
			chk("tick gap", 16'(8 * (c <= int'(DIV_MAX_CODE) ? (1 << c) : 32)), 16'(g));
		end
		wr(OFS_PRESCALER, 16'h0000);
		wr(OFS_RELOAD, 16'h0002);
		wr(OFS_CTRL_STATUS, 16'h0005);
		gap(1, g);
		chk("underflow gap", 16'd24, 16'(g));
		rd_chk(OFS_CTRL_STATUS, 16'h0006);
		rd_chk(OFS_CTRL_STATUS, 16'h0004);
		u0 = uf_cnt;
		i0 = irq_cnt;
		idle(48);
		chk("irq on", 16'(uf_cnt - u0 + 16 * (irq_cnt - i0)), 16'h0022);
		wr(OFS_CTRL_STATUS, 16'h0002);
		u0 = uf_cnt;
		i0 = irq_cnt;
		idle(48);
		chk("irq off", 16'(uf_cnt - u0 + 16 * (irq_cnt - i0)), 16'h0002);
		debug_freeze <= 1'b1;
		gap(1, g);
		chk("freeze gap", 16'd24, 16'(g));
		rd_chk(OFS_CTRL_STATUS, 16'h0002);
		rd_chk(OFS_CTRL_STATUS, 16'h0002);
		wr(OFS_CTRL_STATUS, 16'h0010);
		u0 = uf_cnt;
		idle(100);
		chk("halted", 16'(uf_cnt - u0), 16'h0000);
		debug_freeze <= 1'b0;
		wr(OFS_PRESCALER, 16'h0001);
		wr(OFS_CONFIG, 16'h0006);
		wr(OFS_PRESCALER, 16'h0003);
		wr(OFS_RELOAD, 16'h0005);
		wr(OFS_CONFIG, 16'h0000);
		wr(OFS_PRESCALER, 16'h0003);
		rd_chk(OFS_PRESCALER, 16'h0000);
		gap(0, g);
		gap(0, g);
		chk("locked tick", 16'd16, 16'(g));
		gap(1, g);
		gap(1, g);
		chk("locked reload", 16'd48, 16'(g));
		wr(OFS_CONFIG, 16'h0009);
		wr(OFS_CONFIG, 16'h0010);
		rd_chk(OFS_CONFIG, 16'h0000);
		wr(OFS_COUNT_LOAD, 16'h0001);
		idle(120);
		chk("count locked", 16'h0000, 16'(wd_err));
		// Every error is sticky, so a fresh reset comes between each watchdog case that raises one and the case after it.
		reset_dut();
		wr(OFS_CONFIG, 16'h0010);
		idle(100);
		chk("idle wd", 16'h0000, 16'(wd_err));
		wr(OFS_COUNT_LOAD, 16'h0020);
		rd_chk(OFS_CTRL_STATUS, 16'h0008);
		idle(40);
		rd_chk(OFS_CTRL_STATUS, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			idle(16);
			wr(OFS_COUNT_LOAD, 16'h0002);
		end
		idle(12);
		chk("serviced", 16'h0000, 16'(wd_err));
		idle(40);
		chk("late", 16'h0001, 16'(wd_err));
		reset_dut();
		wr(OFS_CONFIG, 16'h0010);
		wr(OFS_MATCH, 16'h0011);
		idle(60);
		chk("match off", 16'h0000, 16'(wd_err));
		wr(OFS_CONFIG, 16'h0030);
		wr(OFS_COUNT_LOAD, 16'h0004);
		for (int k = 0; k < 4; k++) begin
			idle(16);
			wr(OFS_MATCH, {8'h00, MATCH_KEY});
		end
		idle(2);
		chk("match ok", 16'h0000, 16'(wd_err));
		wr(OFS_MATCH, 16'h005b);
		idle(2);
		chk("bad key", 16'h0001, 16'(wd_err));
		reset_dut();
		wr(OFS_CONFIG, 16'h0030);
		wr(OFS_COUNT_LOAD, 16'h0004);
		idle(16);
		wr(OFS_MATCH, {8'h00, MATCH_KEY});
		wr(OFS_MATCH, {8'h00, MATCH_KEY});
		idle(2);
		chk("double match", 16'h0001, 16'(wd_err));
		// Watchdog on the underflow pulse: period 16 cycles, so three clocks need over 32 cycles.
		reset_dut();
		wr(OFS_RELOAD, 16'h0001);
		wr(OFS_CTRL_STATUS, 16'h0001);
		idle(20);
		wr(OFS_COUNT_LOAD, 16'h0002);
		idle(28);
		chk("wd on underflow", 16'h0000, 16'(wd_err));
		debug_freeze <= 1'b1;
		idle(100);
		chk("wd frozen", 16'h0000, 16'(wd_err));
		debug_freeze <= 1'b0;
		idle(60);
		chk("wd late on underflow", 16'h0001, 16'(wd_err));
		results();
	end
endmodule
